// File: ecsr_bank.sv
// register bank and address map for the ethernet mac and phy control space
`timescale 1ns/10ps
`include "ecsr_defines.svh"

module ecsr_bank (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  // build options
  input  wire ecsr_pkg::ecsr_opt_t  i_opt,
  // control and status interface
  input  wire ecsr_pkg::ecsr_req_t  i_req,
  output logic                      o_waitrequest,
  output logic      [31:0]          o_readdata,
  output logic                      o_readdata_valid,
  // mac status inputs
  input  wire logic [31:0]          i_link_fault_state,
  input  wire logic [31:0]          i_tx_stats_state,
  input  wire logic                 i_tx_frame_done,
  input  wire logic [31:0]          i_tx_frame_len,
  input  wire logic                 i_rx_frame_done,
  input  wire logic [31:0]          i_rx_frame_len,
  input  wire logic                 i_rx_len_mismatch,
  // configuration outputs
  output logic      [31:0]          o_link_fault_gen_config,
  output logic      [31:0]          o_gap_column_removal,
  output logic      [31:0]          o_tx_max_frame_length,
  output logic      [31:0]          o_rx_max_frame_length,
  output logic      [31:0]          o_rx_fcs_forward_config,
  output logic      [31:0]          o_rx_length_check_enable,
  output logic      [31:0]          o_tx_stats_config,
  // statistics and error outputs
  output logic      [31:0]          o_tx_oversize_frame_count,
  output logic      [31:0]          o_rx_oversize_frame_count,
  output logic                      o_rx_length_error
);
  import ecsr_pkg::*;

  // ****************************************************************
  // decode
  // ****************************************************************
  logic [`ECSR_NUM_RNG-1:0]    rng_hit;
  logic [3:0]                  rng_idx;
  logic                        kr_sub_hit;
  logic [7:0]                  loc;
  logic [`ECSR_NUM_RNG-1:0]    scr_wr;
  logic [`ECSR_NUM_RNG*32-1:0] scr_value;
  logic                        wr_ok;

  assign loc   = i_req.addr[7:0];
  assign wr_ok = i_req.wr && !o_waitrequest;

  ecsr_decode u_decode (
    .i_addr       (i_req.addr),
    .i_opt        (i_opt),
    .o_rng_hit    (rng_hit),
    .o_rng_idx    (rng_idx),
    .o_kr_sub_hit (kr_sub_hit)
  );

  always_comb begin
    scr_wr = '0;
    if (wr_ok && loc == `ECSR_LOC_SCRATCH) begin
      scr_wr = rng_hit;
    end
  end

  ecsr_scratch u_scratch (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_wr      (scr_wr),
    .i_wdata   (i_req.wdata),
    .o_value   (scr_value)
  );

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [31:0] next_lf_cfg;
  logic [31:0] next_ipg;
  logic [31:0] next_tx_max;
  logic [31:0] next_rx_max;
  logic [31:0] next_rx_fcs;
  logic [31:0] next_lenchk;
  logic [31:0] next_txst_cfg;

  always_comb begin
    next_lf_cfg   = o_link_fault_gen_config;
    next_ipg      = o_gap_column_removal;
    next_tx_max   = o_tx_max_frame_length;
    next_rx_max   = o_rx_max_frame_length;
    next_rx_fcs   = o_rx_fcs_forward_config;
    next_lenchk   = o_rx_length_check_enable;
    next_txst_cfg = o_tx_stats_config;

    // unlisted, read-only and reserved addresses store nothing
    if (wr_ok) begin
      case (i_req.addr)
        `ECSR_A_LF_CFG: begin
          if (i_opt.link_fault) begin
            next_lf_cfg = i_req.wdata;
          end
        end
        `ECSR_A_IPG_REM: begin
          if (i_opt.avg_ipg) begin
            next_ipg = i_req.wdata;
          end
        end
        `ECSR_A_TX_MAX: begin
          next_tx_max = i_req.wdata;
        end
        `ECSR_A_RX_MAX: begin
          next_rx_max = i_req.wdata;
        end
        `ECSR_A_RX_FCS: begin
          next_rx_fcs = i_req.wdata;
        end
        `ECSR_A_RX_LENCHK: begin
          next_lenchk = i_req.wdata;
        end
        `ECSR_A_TXST_CFG: begin
          if (i_opt.tx_stats) begin
            next_txst_cfg = i_req.wdata;
          end
        end
        default: begin
          next_lf_cfg = o_link_fault_gen_config;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_link_fault_gen_config  <= `ECSR_ZERO32;
      o_gap_column_removal     <= `ECSR_ZERO32;
      o_tx_max_frame_length    <= `ECSR_MAXLEN_RST;
      o_rx_max_frame_length    <= `ECSR_MAXLEN_RST;
      o_rx_fcs_forward_config  <= `ECSR_ZERO32;
      o_rx_length_check_enable <= `ECSR_ZERO32;
      o_tx_stats_config        <= `ECSR_ZERO32;
    end else begin
      o_link_fault_gen_config  <= next_lf_cfg;
      o_gap_column_removal     <= next_ipg;
      o_tx_max_frame_length    <= next_tx_max;
      o_rx_max_frame_length    <= next_rx_max;
      o_rx_fcs_forward_config  <= next_rx_fcs;
      o_rx_length_check_enable <= next_lenchk;
      o_tx_stats_config        <= next_txst_cfg;
    end
  end

  // ****************************************************************
  // oversize counters and length error
  // ****************************************************************
  logic [31:0] next_tx_ovr;
  logic [31:0] next_rx_ovr;
  logic        next_len_err;

  always_comb begin
    next_tx_ovr  = o_tx_oversize_frame_count;
    next_rx_ovr  = o_rx_oversize_frame_count;
    next_len_err = 1'b0;

    if (i_tx_frame_done && i_tx_frame_len > o_tx_max_frame_length) begin
      next_tx_ovr = o_tx_oversize_frame_count + `ECSR_ONE32;
    end

    if (i_rx_frame_done && i_rx_frame_len > o_rx_max_frame_length) begin
      next_rx_ovr = o_rx_oversize_frame_count + `ECSR_ONE32;
    end

    if (i_rx_frame_done && i_rx_len_mismatch && o_rx_length_check_enable[0]) begin
      next_len_err = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_tx_oversize_frame_count <= `ECSR_ZERO32;
      o_rx_oversize_frame_count <= `ECSR_ZERO32;
      o_rx_length_error         <= 1'b0;
    end else begin
      o_tx_oversize_frame_count <= next_tx_ovr;
      o_rx_oversize_frame_count <= next_rx_ovr;
      o_rx_length_error         <= next_len_err;
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  logic [31:0] rd_value;

  always_comb begin
    rd_value = `ECSR_RESERVED_VAL;
    if (rng_hit != '0) begin
      case (loc)
        `ECSR_LOC_REVID: begin
          rd_value = `ECSR_REVID_VAL;
        end
        `ECSR_LOC_SCRATCH: begin
          rd_value = scr_value[rng_idx*32 +: 32];
        end
        `ECSR_LOC_NAME0: begin
          rd_value = `ECSR_NAME0_VAL;
        end
        `ECSR_LOC_NAME1: begin
          rd_value = `ECSR_NAME1_VAL;
        end
        `ECSR_LOC_NAME2: begin
          rd_value = `ECSR_NAME2_VAL;
        end
        default: begin
          rd_value = `ECSR_RESERVED_VAL;
        end
      endcase
    end

    // kr sub-range contents live outside this bank and read the fixed value
    if (kr_sub_hit) begin
      rd_value = `ECSR_RESERVED_VAL;
    end

    case (i_req.addr)
      `ECSR_A_LF_CFG: begin
        if (i_opt.link_fault) begin
          rd_value = o_link_fault_gen_config;
        end
      end
      `ECSR_A_IPG_REM: begin
        if (i_opt.avg_ipg) begin
          rd_value = o_gap_column_removal;
        end
      end
      `ECSR_A_TX_MAX: begin
        rd_value = o_tx_max_frame_length;
      end
      `ECSR_A_RX_MAX: begin
        rd_value = o_rx_max_frame_length;
      end
      `ECSR_A_RX_FCS: begin
        rd_value = o_rx_fcs_forward_config;
      end
      `ECSR_A_LF_STATE: begin
        if (i_opt.link_fault) begin
          rd_value = i_link_fault_state;
        end else begin
          rd_value = `ECSR_ZERO32;
        end
      end
      `ECSR_A_RX_LENCHK: begin
        rd_value = o_rx_length_check_enable;
      end
      `ECSR_A_TXST_CFG: begin
        if (i_opt.tx_stats) begin
          rd_value = o_tx_stats_config;
        end
      end
      `ECSR_A_TXST_STATE: begin
        if (i_opt.tx_stats) begin
          rd_value = i_tx_stats_state;
        end
      end
      default: begin
        // other addresses keep the range result
      end
    endcase
  end

  // ****************************************************************
  // response handshake
  // ****************************************************************
  ecsr_state_t state;
  ecsr_state_t next_state;
  logic [31:0] next_rdata;
  logic        next_rvalid;

  always_comb begin
    next_state  = state;
    next_rdata  = o_readdata;
    next_rvalid = 1'b0;

    case (state)
      ECSR_IDLE: begin
        if (i_req.rd) begin
          next_state  = ECSR_RESP;
          next_rdata  = rd_value;
          next_rvalid = 1'b1;
        end
      end
      ECSR_RESP: begin
        next_state = ECSR_IDLE;
      end
      default: begin
        next_state = ECSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state            <= ECSR_IDLE;
      o_readdata       <= `ECSR_ZERO32;
      o_readdata_valid <= 1'b0;
    end else begin
      state            <= next_state;
      o_readdata       <= next_rdata;
      o_readdata_valid <= next_rvalid;
    end
  end

  // reads stall one cycle; writes never stall
  always_comb begin
    o_waitrequest = 1'b0;
    if (i_req.rd && (state == ECSR_IDLE)) begin
      o_waitrequest = 1'b1;
    end
  end
endmodule : ecsr_bank

// File: ecsr_defines.svh
// address map constants for the ethernet control and status register bank
`ifndef ECSR_DEFINES_SVH
`define ECSR_DEFINES_SVH

// ****************************************************************
// ranges (word address bits [11:8])
// ****************************************************************
`define ECSR_RNG_KR       4'h0
`define ECSR_RNG_PHY      4'h3
`define ECSR_RNG_TXMAC    4'h4
`define ECSR_RNG_RXMAC    4'h5
`define ECSR_RNG_TXPAUSE  4'h6
`define ECSR_RNG_RXPAUSE  4'h7
`define ECSR_RNG_TXSTAT   4'h8
`define ECSR_RNG_RXSTAT   4'h9
`define ECSR_RNG_TXPTP    4'hA
`define ECSR_RNG_RXPTP    4'hB
`define ECSR_NUM_RNG      10

// ****************************************************************
// local offsets common to every range except kr
// ****************************************************************
`define ECSR_LOC_REVID    8'h00
`define ECSR_LOC_SCRATCH  8'h01
`define ECSR_LOC_NAME0    8'h02
`define ECSR_LOC_NAME1    8'h03
`define ECSR_LOC_NAME2    8'h04

// ****************************************************************
// kr sub-ranges
// ****************************************************************
`define ECSR_KR_LO        8'hB0
`define ECSR_KR_TOP_HI    8'hB7
`define ECSR_KR_FEC_HI    8'hBD
`define ECSR_AN_LO        8'hC0
`define ECSR_AN_HI        8'hCC
`define ECSR_LT_LO        8'hD0
`define ECSR_LT_HI        8'hEB

// ****************************************************************
// config and status register word addresses
// ****************************************************************
`define ECSR_A_LF_CFG     12'h405
`define ECSR_A_IPG_REM    12'h406
`define ECSR_A_TX_MAX     12'h407
`define ECSR_A_RX_MAX     12'h506
`define ECSR_A_RX_FCS     12'h507
`define ECSR_A_LF_STATE   12'h508
`define ECSR_A_RX_LENCHK  12'h50A
`define ECSR_A_TXST_CFG   12'h845
`define ECSR_A_TXST_STATE 12'h846

// ****************************************************************
// reset and fixed values
// ****************************************************************
`define ECSR_RESERVED_VAL 32'h0000_0000
`define ECSR_REVID_VAL    32'h0000_0001
`define ECSR_NAME0_VAL    32'h2020_2020
`define ECSR_NAME1_VAL    32'h2020_2020
`define ECSR_NAME2_VAL    32'h2020_2020
`define ECSR_MAXLEN_RST   32'h0000_05EE
`define ECSR_ZERO32       32'h0000_0000
`define ECSR_ONE32        32'h0000_0001

`endif

// File: ecsr_pkg.sv
// types for the ethernet control and status register bank
package ecsr_pkg;
  typedef enum logic [1:0] {
    ECSR_IDLE = 2'b00,
    ECSR_RESP = 2'b01
  } ecsr_state_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ecsr_req_t;

  typedef struct packed {
    logic        kr;
    logic        fec;
    logic        an;
    logic        lt;
    logic        link_fault;
    logic        avg_ipg;
    logic        pause;
    logic        tx_stats;
    logic        rx_stats;
    logic        ptp;
  } ecsr_opt_t;
endpackage : ecsr_pkg

// File: ecsr_scratch.sv
// per-range scratch registers
`timescale 1ns/10ps
`include "ecsr_defines.svh"
module ecsr_scratch (
  // clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_sys_rst,
  // write strobes and data
  input  wire logic [`ECSR_NUM_RNG-1:0]  i_wr,
  input  wire logic [31:0]               i_wdata,
  // stored values
  output logic      [`ECSR_NUM_RNG*32-1:0] o_value
);
  import ecsr_pkg::*;
  logic [`ECSR_NUM_RNG*32-1:0] next_value;

  always_comb begin
    next_value = o_value;
    for (int k = 0; k < `ECSR_NUM_RNG; k++) begin
      if (i_wr[k]) begin
        next_value[k*32 +: 32] = i_wdata;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_value <= '0;
    end else begin
      o_value <= next_value;
    end
  end
endmodule : ecsr_scratch

// File: ecsr_decode.sv
// range and option decode of a word address
`timescale 1ns/10ps
`include "ecsr_defines.svh"
module ecsr_decode (
  // address and build options
  input  wire logic [11:0]              i_addr,
  input  wire ecsr_pkg::ecsr_opt_t      i_opt,
  // decode results
  output logic      [`ECSR_NUM_RNG-1:0] o_rng_hit,
  output logic      [3:0]               o_rng_idx,
  output logic                          o_kr_sub_hit
);
  import ecsr_pkg::*;
  logic [3:0] rng;
  logic [7:0] loc;

  always_comb begin
    rng          = i_addr[11:8];
    loc          = i_addr[7:0];
    o_rng_hit    = '0;
    o_rng_idx    = 4'h0;
    o_kr_sub_hit = 1'b0;
    case (rng)
      `ECSR_RNG_KR: begin
        // low space is reserved apart from kr sub-ranges
        if (i_opt.kr && loc >= `ECSR_KR_LO && loc <= `ECSR_KR_TOP_HI) o_kr_sub_hit = 1'b1;
        if (i_opt.kr && i_opt.fec && loc > `ECSR_KR_TOP_HI && loc <= `ECSR_KR_FEC_HI) o_kr_sub_hit = 1'b1;
        if (i_opt.kr && i_opt.an && loc >= `ECSR_AN_LO && loc <= `ECSR_AN_HI) o_kr_sub_hit = 1'b1;
        if (i_opt.kr && i_opt.lt && loc >= `ECSR_LT_LO && loc <= `ECSR_LT_HI) o_kr_sub_hit = 1'b1;
      end
      `ECSR_RNG_PHY: begin
        o_rng_hit[1] = 1'b1;
        o_rng_idx    = 4'h1;
      end
      `ECSR_RNG_TXMAC: begin
        o_rng_hit[2] = 1'b1;
        o_rng_idx    = 4'h2;
      end
      `ECSR_RNG_RXMAC: begin
        o_rng_hit[3] = 1'b1;
        o_rng_idx    = 4'h3;
      end
      `ECSR_RNG_TXPAUSE: begin
        o_rng_hit[4] = i_opt.pause;
        o_rng_idx    = 4'h4;
      end
      `ECSR_RNG_RXPAUSE: begin
        o_rng_hit[5] = i_opt.pause;
        o_rng_idx    = 4'h5;
      end
      `ECSR_RNG_TXSTAT: begin
        o_rng_hit[6] = i_opt.tx_stats;
        o_rng_idx    = 4'h6;
      end
      `ECSR_RNG_RXSTAT: begin
        o_rng_hit[7] = i_opt.rx_stats;
        o_rng_idx    = 4'h7;
      end
      `ECSR_RNG_TXPTP: begin
        o_rng_hit[8] = i_opt.ptp;
        o_rng_idx    = 4'h8;
      end
      `ECSR_RNG_RXPTP: begin
        o_rng_hit[9] = i_opt.ptp;
        o_rng_idx    = 4'h9;
      end
      default: begin o_rng_hit = '0; end
    endcase
  end
endmodule : ecsr_decode

// File: ecsr_bank_checker.sv
// concurrent checks on the ports of the register bank
`timescale 1ns/10ps
`include "ecsr_defines.svh"
module ecsr_bank_checker (
  // clock and reset
  input  wire logic                i_clk,
  input  wire logic                i_sys_rst,
  // options, requests and responses
  input  wire ecsr_pkg::ecsr_opt_t i_opt,
  input  wire ecsr_pkg::ecsr_req_t i_req,
  input  wire logic                o_waitrequest,
  input  wire logic [31:0]         o_readdata,
  input  wire logic                o_readdata_valid,
  // frame events
  input  wire logic                i_tx_frame_done,
  input  wire logic [31:0]         i_tx_frame_len,
  input  wire logic                i_rx_frame_done,
  input  wire logic                i_rx_len_mismatch,
  // register outputs
  input  wire logic [31:0]         o_link_fault_gen_config,
  input  wire logic [31:0]         o_gap_column_removal,
  input  wire logic [31:0]         o_tx_max_frame_length,
  input  wire logic [31:0]         o_rx_length_check_enable,
  input  wire logic [31:0]         o_tx_stats_config,
  input  wire logic [31:0]         o_tx_oversize_frame_count,
  input  wire logic                o_rx_length_error
);
  import ecsr_pkg::*;
  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  rd_stall_a: assert property (i_req.rd |-> o_waitrequest == !o_readdata_valid)
    else $error("read stall does not follow the read phase");
  wr_nostall_a: assert property (!i_req.rd |-> !o_waitrequest)
    else $error("stall without a read");
  rd_answer_a: assert property (i_req.rd && o_waitrequest |=> o_readdata_valid ##1 !o_readdata_valid)
    else $error("read data valid is not a single pulse");
  resv_read_a: assert property (i_req.rd && o_waitrequest && i_req.addr[11:8] < 4'h3 |=>
    o_readdata == `ECSR_RESERVED_VAL)
    else $error("low space read is not the fixed value");
  txmax_wr_a: assert property (i_req.wr && i_req.addr == 12'h407 |=>
    o_tx_max_frame_length == $past(i_req.wdata))
    else $error("tx max length write lost");
  lfcfg_gate_a: assert property (i_req.wr && i_req.addr == 12'h405 && !i_opt.link_fault |=>
    $stable(o_link_fault_gen_config))
    else $error("link fault config written without option");
  ipg_gate_a: assert property (i_req.wr && i_req.addr == 12'h406 && !i_opt.avg_ipg |=>
    $stable(o_gap_column_removal))
    else $error("gap removal written without option");
  txst_gate_a: assert property (i_req.wr && i_req.addr == 12'h845 && !i_opt.tx_stats |=>
    $stable(o_tx_stats_config))
    else $error("tx stats config written without option");
  txovs_inc_a: assert property (i_tx_frame_done && i_tx_frame_len > o_tx_max_frame_length |=>
    o_tx_oversize_frame_count == $past(o_tx_oversize_frame_count) + 32'h1)
    else $error("tx oversize count missed a frame");
  txovs_hold_a: assert property (i_tx_frame_done && i_tx_frame_len <= o_tx_max_frame_length |=>
    $stable(o_tx_oversize_frame_count))
    else $error("tx oversize count moved on a legal frame");
  lenerr_set_a: assert property (i_rx_frame_done && i_rx_len_mismatch && o_rx_length_check_enable[0] |=>
    o_rx_length_error)
    else $error("length error not flagged");
  lenerr_quiet_a: assert property (!(i_rx_frame_done && i_rx_len_mismatch && o_rx_length_check_enable[0]) |=>
    !o_rx_length_error)
    else $error("length error without cause");
endmodule : ecsr_bank_checker

// File: tb_top.sv
// self-checking testbench for the register bank
`timescale 1ns/10ps
`include "ecsr_defines.svh"
module tb_top;
  import ecsr_pkg::*;
  logic        i_clk, i_sys_rst, o_waitrequest, o_readdata_valid, o_rx_length_error;
  ecsr_opt_t   i_opt;
  ecsr_req_t   i_req;
  logic [31:0] o_readdata, i_link_fault_state, i_tx_stats_state, i_tx_frame_len, i_rx_frame_len;
  logic        i_tx_frame_done, i_rx_frame_done, i_rx_len_mismatch, lerr;
  logic [31:0] o_link_fault_gen_config, o_gap_column_removal, o_tx_max_frame_length, o_rx_max_frame_length;
  logic [31:0] o_rx_fcs_forward_config, o_rx_length_check_enable, o_tx_stats_config;
  logic [31:0] o_tx_oversize_frame_count, o_rx_oversize_frame_count;
  int          err_total = 0;
  int          n_tests = 0;
  ecsr_bank ecsr_bank_inst (.i_clk, .i_sys_rst, .i_opt, .i_req, .o_waitrequest, .o_readdata, .o_readdata_valid,
    .i_link_fault_state, .i_tx_stats_state, .i_tx_frame_done, .i_tx_frame_len, .i_rx_frame_done, .i_rx_frame_len,
    .i_rx_len_mismatch, .o_link_fault_gen_config, .o_gap_column_removal, .o_tx_max_frame_length,
    .o_rx_max_frame_length, .o_rx_fcs_forward_config, .o_rx_length_check_enable, .o_tx_stats_config,
    .o_tx_oversize_frame_count, .o_rx_oversize_frame_count, .o_rx_length_error);
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge i_clk);
    i_req.wr <= 1'b0;
    // let the written register settle before any output compare
    @(negedge i_clk);
  endtask : wr
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
    int n;
    @(posedge i_clk);
    i_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 32'h0};
    @(posedge i_clk);
    n = 0;
    while (o_waitrequest !== 1'b0 && n < 8) begin
      @(posedge i_clk);
      n++;
    end
    chk({31'h0, o_readdata_valid}, 32'h1, "read valid");
    chk(o_readdata, exp, what);
    i_req.rd <= 1'b0;
  endtask : rchk
  task automatic frame(input logic [31:0] tlen, input logic [31:0] rlen, input logic mm);
    @(posedge i_clk);
    i_tx_frame_done <= 1'b1;
    i_rx_frame_done <= 1'b1;
    i_tx_frame_len <= tlen;
    i_rx_frame_len <= rlen;
    i_rx_len_mismatch <= mm;
    @(posedge i_clk);
    i_tx_frame_done <= 1'b0;
    i_rx_frame_done <= 1'b0;
    @(posedge i_clk);
    lerr = o_rx_length_error;
  endtask : frame
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  // ****************************************************************
  // clock, watchdog and tests
  // ****************************************************************
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    end_of_test();
  end
  initial begin
    i_sys_rst = 1'b1;
    i_opt = '1;
    i_req = '0;
    i_link_fault_state = 32'h0000_000F;
    i_tx_stats_state = 32'h0000_1234;
    {i_tx_frame_done, i_rx_frame_done, i_rx_len_mismatch, i_tx_frame_len, i_rx_frame_len} = '0;
    repeat (5) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rchk(12'h301, 32'h0, "scratch after reset");
    chk(o_tx_max_frame_length, `ECSR_MAXLEN_RST, "tx max reset");
    $display("test reset done");
    for (int r = 3; r < 12; r++) wr({r[3:0], 8'h01}, 32'h5A00_0000 | 32'(r));
    for (int r = 3; r < 12; r++) begin
      rchk({r[3:0], 8'h01}, 32'h5A00_0000 | 32'(r), "scratch");
      rchk({r[3:0], 8'h00}, `ECSR_REVID_VAL, "revision");
      rchk({r[3:0], 8'h02}, `ECSR_NAME0_VAL, "name");
    end
    $display("test ranges done");
    wr(12'h300, 32'hFFFF_FFFF);
    rchk(12'h300, `ECSR_REVID_VAL, "revision after write");
    wr(12'h846, 32'h0);
    rchk(12'h846, 32'h0000_1234, "tx stats state");
    wr(12'h010, 32'hDEAD_BEEF);
    wr(12'hC01, 32'hDEAD_BEEF);
    rchk(12'h010, 32'h0, "reserved first");
    rchk(12'h010, 32'h0, "reserved second");
    rchk(12'h201, 32'h0, "low space");
    rchk(12'hC01, 32'h0, "unmapped");
    rchk(12'h0B0, 32'h0, "kr area");
    chk(o_tx_max_frame_length, `ECSR_MAXLEN_RST, "no side effect");
    $display("test read-only and reserved done");
    wr(12'h405, 32'h0000_0003);
    chk(o_link_fault_gen_config, 32'h0000_0003, "link fault config");
    wr(12'h406, 32'h0000_0002);
    chk(o_gap_column_removal, 32'h0000_0002, "gap removal");
    wr(12'h407, 32'h0000_0064);
    wr(12'h506, 32'h0000_00C8);
    chk(o_rx_max_frame_length, 32'h0000_00C8, "rx max");
    wr(12'h507, 32'h0000_0001);
    chk(o_rx_fcs_forward_config, 32'h0000_0001, "fcs forward");
    wr(12'h50A, 32'h0000_0001);
    wr(12'h845, 32'h0000_0005);
    chk(o_tx_stats_config, 32'h0000_0005, "tx stats config");
    rchk(12'h508, 32'h0000_000F, "link fault state");
    rchk(12'h405, 32'h0000_0003, "read link fault config");
    rchk(12'h406, 32'h0000_0002, "read gap removal");
    rchk(12'h407, 32'h0000_0064, "read tx max");
    rchk(12'h506, 32'h0000_00C8, "read rx max");
    rchk(12'h507, 32'h0000_0001, "read fcs forward");
    rchk(12'h50A, 32'h0000_0001, "read length check");
    rchk(12'h845, 32'h0000_0005, "read tx stats config");
    $display("test config done");
    frame(32'h0000_0065, 32'h0000_00C8, 1'b0);
    chk(o_tx_oversize_frame_count, 32'h1, "tx oversize");
    chk(o_rx_oversize_frame_count, 32'h0, "rx at limit");
    frame(32'h0000_0064, 32'h0000_00C9, 1'b1);
    chk(o_tx_oversize_frame_count, 32'h1, "tx at limit");
    chk(o_rx_oversize_frame_count, 32'h1, "rx oversize");
    chk({31'h0, lerr}, 32'h1, "length error");
    wr(12'h50A, 32'h0);
    frame(32'h0, 32'h0, 1'b1);
    chk({31'h0, lerr}, 32'h0, "length check off");
    $display("test frames done");
    i_opt <= '{kr: 1'b0, fec: 1'b0, an: 1'b0, lt: 1'b0, link_fault: 1'b0, avg_ipg: 1'b0, pause: 1'b0,
               tx_stats: 1'b0, rx_stats: 1'b0, ptp: 1'b0};
    wr(12'h405, 32'h0000_00FF);
    wr(12'h406, 32'h0000_00FF);
    wr(12'h845, 32'h0000_00FF);
    wr(12'h601, 32'h0000_00FF);
    chk(o_link_fault_gen_config, 32'h0000_0003, "gated link fault config");
    rchk(12'h405, 32'h0, "link fault config read off");
    chk(o_gap_column_removal, 32'h0000_0002, "gated gap removal");
    chk(o_tx_stats_config, 32'h0000_0005, "gated tx stats config");
    rchk(12'h508, 32'h0, "link fault state off");
    rchk(12'h601, 32'h0, "tx pause off");
    rchk(12'h701, 32'h0, "rx pause off");
    rchk(12'h846, 32'h0, "tx stats state off");
    rchk(12'h901, 32'h0, "rx stats off");
    rchk(12'hA01, 32'h0, "ptp off");
    rchk(12'h301, 32'h5A00_0003, "phy always");
    $display("test options done");
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rchk(12'h301, 32'h0, "scratch second reset");
    $display("test second reset done");
    end_of_test();
  end
endmodule : tb_top

bind ecsr_bank ecsr_bank_checker ecsr_bank_checker_inst (.i_clk, .i_sys_rst, .i_opt, .i_req, .o_waitrequest,
  .o_readdata, .o_readdata_valid, .i_tx_frame_done, .i_tx_frame_len, .i_rx_frame_done, .i_rx_len_mismatch,
  .o_link_fault_gen_config, .o_gap_column_removal, .o_tx_max_frame_length, .o_rx_length_check_enable,
  .o_tx_stats_config, .o_tx_oversize_frame_count, .o_rx_length_error);
